// ==== mcp_control.sv ====
// module control pin handler: tx disable, low power, reset and monitor clock
`timescale 1ns/100ps
module mcp_control #(
    parameter logic [15:0] MS_CYCLES = mcp_pkg::MS_CYCLES,
    parameter logic [17:0] INIT_MS   = mcp_pkg::INIT_MS
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          reset_n,
    // host control pins
    input  wire logic          optical_output_off_request,
    input  wire logic          low_power_request,
    input  wire logic          module_hold_in_reset_n,
    // one pulse per transmitted symbol
    input  wire logic          symbol_tick,
    // module state
    output mcp_pkg::mcp_status_t status,
    output logic               tx_monitor_clock
);

    mcp_pkg::mcp_pins_t   pins_raw;
    mcp_pkg::mcp_pins_t   pins;
    logic [mcp_pkg::PIN_COUNT-1:0] pins_vec;

    mcp_pkg::mcp_state_t  state_reg;
    mcp_pkg::mcp_state_t  state_next;
    logic [15:0]          ms_cnt_reg;
    logic [15:0]          ms_cnt_next;
    logic [17:0]          init_cnt_reg;
    logic [17:0]          init_cnt_next;
    logic                 ms_tick;
    logic                 init_done;
    logic [4:0]           sym_cnt_reg;
    logic [4:0]           sym_cnt_next;
    logic                 txm_reg;
    logic                 txm_next;
    mcp_pkg::mcp_status_t status_reg;
    mcp_pkg::mcp_status_t status_next;

    assign pins_raw.optical_output_off_request = optical_output_off_request;
    assign pins_raw.low_power_request          = low_power_request;
    assign pins_raw.module_hold_in_reset_n     = module_hold_in_reset_n;

    mcp_sync u_sync (
        .clock     (clock),
        .reset_n   (reset_n),
        .pins_in   (pins_raw),
        .pins_sync (pins_vec)
    );
    assign pins = pins_vec;

    assign ms_tick   = (ms_cnt_reg == MS_CYCLES - 16'h0001);
    // done at the minimum time, well inside the maximum
    assign init_done = ms_tick && (init_cnt_reg == INIT_MS - 18'h00001);

    always_comb begin
        state_next    = state_reg;
        ms_cnt_next   = ms_cnt_reg;
        init_cnt_next = init_cnt_reg;
        unique case (state_reg)
            mcp_pkg::MCP_ST_RESET: begin
                ms_cnt_next   = 16'h0000;
                init_cnt_next = 18'h00000;
                if (pins.module_hold_in_reset_n) begin
                    state_next = mcp_pkg::MCP_ST_INIT;
                end
            end
            mcp_pkg::MCP_ST_INIT: begin
                ms_cnt_next = ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
                if (ms_tick) begin
                    init_cnt_next = init_cnt_reg + 18'h00001;
                end
                if (init_done) begin
                    state_next = pins.low_power_request ? mcp_pkg::MCP_ST_LOW_POWER
                                                        : mcp_pkg::MCP_ST_NORMAL;
                end
            end
            mcp_pkg::MCP_ST_LOW_POWER: begin
                // go to full power on release
                if (!pins.low_power_request) begin
                    state_next = mcp_pkg::MCP_ST_NORMAL;
                end
            end
            mcp_pkg::MCP_ST_NORMAL: begin
                if (pins.low_power_request) begin
                    state_next = mcp_pkg::MCP_ST_LOW_POWER;
                end
            end
        endcase
        if (!pins.module_hold_in_reset_n) begin
            state_next = mcp_pkg::MCP_ST_RESET;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= mcp_pkg::MCP_ST_RESET;
            ms_cnt_reg   <= 16'h0000;
            init_cnt_reg <= 18'h00000;
        end else begin
            state_reg    <= state_next;
            ms_cnt_reg   <= ms_cnt_next;
            init_cnt_reg <= init_cnt_next;
        end
    end

    // status follows the next state so outputs line up with state_reg
    always_comb begin
        status_next                    = '0;
        status_next.in_reset           = (state_next == mcp_pkg::MCP_ST_RESET);
        status_next.init_busy          = (state_next == mcp_pkg::MCP_ST_INIT);
        status_next.low_power_mode     = (state_next == mcp_pkg::MCP_ST_LOW_POWER);
        status_next.operational        = (state_next == mcp_pkg::MCP_ST_NORMAL);
        // management kept up in low power
        status_next.mgmt_access_enable = status_next.low_power_mode
                                       || status_next.operational;
        // on whenever request low at full power
        // laser gated by full power: an uninitialized module cannot emit safely
        status_next.optical_output_on  = status_next.operational
                                       && !pins.optical_output_off_request;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status = status_reg;

    always_comb begin
        sym_cnt_next = sym_cnt_reg;
        txm_next     = txm_reg;
        if (symbol_tick) begin
            if (sym_cnt_reg == mcp_pkg::TXM_HALF_LAST) begin
                sym_cnt_next = 5'h00;
                txm_next     = !txm_reg;
            end else begin
                sym_cnt_next = sym_cnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sym_cnt_reg <= 5'h00;
            txm_reg     <= 1'b0;
        end else begin
            sym_cnt_reg <= sym_cnt_next;
            txm_reg     <= txm_next;
        end
    end

    assign tx_monitor_clock = txm_reg;

    AST_TX_OFF: assert property (
        @(posedge clock) disable iff (!reset_n)
        pins.optical_output_off_request |=> !status.optical_output_on)
        else $error("optical output on while off request high");

    AST_TX_ON: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_reg == mcp_pkg::MCP_ST_NORMAL) && pins.low_power_request == 1'b0
        && pins.module_hold_in_reset_n && !pins.optical_output_off_request
        |=> status.optical_output_on)
        else $error("optical output off while enabled at full power");

    AST_LP_HOLD: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_reg == mcp_pkg::MCP_ST_LOW_POWER) && pins.low_power_request
        && pins.module_hold_in_reset_n
        |=> (state_reg == mcp_pkg::MCP_ST_LOW_POWER) && status.low_power_mode)
        else $error("left low power while still requested");

    AST_LP_EXIT: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_reg == mcp_pkg::MCP_ST_LOW_POWER) && !pins.low_power_request
        && pins.module_hold_in_reset_n
        |=> status.operational && !status.low_power_mode)
        else $error("no full power after low power release");

    AST_MGMT: assert property (
        @(posedge clock) disable iff (!reset_n)
        status.low_power_mode |-> status.mgmt_access_enable && !status.optical_output_on)
        else $error("management unavailable in low power");

    AST_RST_HOLD: assert property (
        @(posedge clock) disable iff (!reset_n)
        !pins.module_hold_in_reset_n |=> status.in_reset && !status.optical_output_on)
        else $error("not in reset while reset pin held");

    AST_INIT_START: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_reg == mcp_pkg::MCP_ST_RESET) && pins.module_hold_in_reset_n
        |=> status.init_busy && init_cnt_reg == 18'h00000)
        else $error("init not started on reset release");

    AST_INIT_TIME: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_reg == mcp_pkg::MCP_ST_INIT) ##1 (state_reg != mcp_pkg::MCP_ST_INIT)
        && $past(pins.module_hold_in_reset_n)
        |-> $past(init_cnt_reg) == INIT_MS - 18'h00001
            && $past(ms_cnt_reg) == MS_CYCLES - 16'h0001)
        else $error("init ended at wrong time");

    AST_TXM_DIV: assert property (
        @(posedge clock) disable iff (!reset_n)
        $changed(tx_monitor_clock)
        |-> $past(symbol_tick) && $past(sym_cnt_reg) == mcp_pkg::TXM_HALF_LAST)
        else $error("monitor clock toggled off the 24th symbol");

endmodule : mcp_control

// ==== mcp_host_model.sv ====
// host card model driving the module control pins and the symbol ticks
`timescale 1ns/100ps
module mcp_host_model (
    // clock
    input  wire logic       clock,
    // commands from the bench: off request, low power, hold-in-reset
    input  wire logic [2:0] pins_cmd,
    input  wire logic       tick_cmd,
    // module pins
    output logic            optical_output_off_request,
    output logic            low_power_request,
    output logic            module_hold_in_reset_n,
    output logic            symbol_tick
);
    // pins move just after the edge, like host glue logic
    initial begin
        optical_output_off_request = 1'b1;
        low_power_request          = 1'b1;
        module_hold_in_reset_n     = 1'b0;
        symbol_tick                = 1'b0;
    end
    always @(posedge clock) begin
        {optical_output_off_request, low_power_request, module_hold_in_reset_n} <= pins_cmd;
        symbol_tick <= tick_cmd;
    end
endmodule : mcp_host_model

// ==== mcp_pkg.sv ====
// constants and types for the module control pin handler
// Overview of operation
// - optical output stays off while the output-off request is high
// - optical output turns on while the output-off request is low at full power
// - low-power request high holds the module in its low-power state
// - low-power request low brings the module up into full-power operation
// - management access stays available during the low-power state
// - while the active-low hold-in-reset pin is low, the module stays in reset
// - rising hold-in-reset pin starts the power-on initialization sequence
// - transmit monitor clock runs at one forty-eighth of the symbol rate
// - all timing comes from the internal local clock, no host reference clock
// - initialization ends between the minimum and maximum time after reset
package mcp_pkg;

    localparam int          CLOCK_HZ      = 50_000_000;
    localparam int          LOCAL_REF_HZ  = 622_080_000;
    localparam int          MS_PER_S      = 1000;
    localparam int          INIT_MIN_S    = 190;
    localparam int          INIT_MAX_S    = 220;
    localparam logic [15:0] MS_CYCLES     = 16'(CLOCK_HZ / MS_PER_S);
    localparam logic [17:0] INIT_MS       = 18'(INIT_MIN_S * MS_PER_S);
    localparam int          TXM_DIVIDE    = 48;
    localparam logic [4:0]  TXM_HALF_LAST = 5'(TXM_DIVIDE / 2 - 1);
    localparam int          PIN_COUNT     = 3;
    // safe pin levels during chip reset: output off, low power, held in reset
    localparam logic [2:0]  PIN_RST_VAL   = 3'h6;

    typedef enum logic [1:0] {
        MCP_ST_RESET     = 2'b00,
        MCP_ST_INIT      = 2'b01,
        MCP_ST_LOW_POWER = 2'b10,
        MCP_ST_NORMAL    = 2'b11
    } mcp_state_t;

    // host pins, bit order fixed so the synchronizer can take a vector
    typedef struct packed {
        logic optical_output_off_request;
        logic low_power_request;
        logic module_hold_in_reset_n;
    } mcp_pins_t;

    typedef struct packed {
        logic optical_output_on;
        logic low_power_mode;
        logic in_reset;
        logic init_busy;
        logic operational;
        logic mgmt_access_enable;
    } mcp_status_t;

endpackage : mcp_pkg

// ==== mcp_sync.sv ====
// two-stage synchronizer for the host control pins
`timescale 1ns/100ps
module mcp_sync (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        reset_n,
    // pins
    input  wire logic [mcp_pkg::PIN_COUNT-1:0] pins_in,
    output logic      [mcp_pkg::PIN_COUNT-1:0] pins_sync
);

    logic [mcp_pkg::PIN_COUNT-1:0] meta_reg;
    logic [mcp_pkg::PIN_COUNT-1:0] sync_reg;

    genvar i;
    generate
        for (i = 0; i < mcp_pkg::PIN_COUNT; i++) begin : g_bit
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    meta_reg[i] <= mcp_pkg::PIN_RST_VAL[i];
                    sync_reg[i] <= mcp_pkg::PIN_RST_VAL[i];
                end else begin
                    meta_reg[i] <= pins_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign pins_sync = sync_reg;

endmodule : mcp_sync

// ==== mcp_testbench.sv ====
// self-checking bench for the module control pin handler
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        logic [2:0] pins;
        logic [5:0] exp;
    } mcp_row_t;
    // pins are {off request, low power, hold-in-reset_n}
    localparam mcp_row_t ROWS [6] = '{
        '{3'h1, 6'h23}, '{3'h5, 6'h03}, '{3'h3, 6'h11},
        '{3'h7, 6'h11}, '{3'h1, 6'h23}, '{3'h0, 6'h08}};
    logic                 clock = 1'b0;
    logic                 reset_n = 1'b0;
    logic [2:0]           pins_cmd = 3'h6;
    logic                 tick_cmd = 1'b0;
    logic                 off_req, low_pwr, hold_n, symbol_tick, tx_monitor_clock, prev;
    mcp_pkg::mcp_status_t status;
    int                   n_fail = 0;
    int                   samples_checked = 0;
    int                   n, toggles;

    always #10 clock = ~clock;

    mcp_host_model u_host (
        .clock                      (clock),
        .pins_cmd                   (pins_cmd),
        .tick_cmd                   (tick_cmd),
        .optical_output_off_request (off_req),
        .low_power_request          (low_pwr),
        .module_hold_in_reset_n     (hold_n),
        .symbol_tick                (symbol_tick)
    );
    // shortened init: 4 cycles per ms, 5 ms, so 20 cycles
    mcp_control #(.MS_CYCLES(16'h0004), .INIT_MS(18'h00005)) u_dut (
        .clock                      (clock),
        .reset_n                    (reset_n),
        .optical_output_off_request (off_req),
        .low_power_request          (low_pwr),
        .module_hold_in_reset_n     (hold_n),
        .symbol_tick                (symbol_tick),
        .status                     (status),
        .tx_monitor_clock           (tx_monitor_clock)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic apply(input logic [2:0] pins, input logic [5:0] exp);
        @(posedge clock);
        pins_cmd <= pins;
        repeat (7) @(negedge clock);
        check(8'(status), 8'(exp));
    endtask : apply

    // init length counted on settled values, laser must stay dark meanwhile
    task automatic measure_init(input logic [5:0] exp);
        n = 0;
        for (int i = 0; i < 20 && status.init_busy !== 1'b1; i++) @(negedge clock);
        for (int i = 0; i < 100 && status.init_busy === 1'b1; i++) begin
            if (status.optical_output_on !== 1'b0) check(8'h1, 8'h0);
            n++;
            @(negedge clock);
        end
        check(8'(n), 8'd20);
        check(8'(status), 8'(exp));
    endtask : measure_init

    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        check(8'(status), 8'h00);
        check(8'(tx_monitor_clock), 8'h00);
        @(posedge clock);
        reset_n <= 1'b1;
        repeat (5) @(negedge clock);
        check(8'(status), 8'h08);
        @(posedge clock);
        pins_cmd <= 3'h1;
        measure_init(6'h23);
        foreach (ROWS[i]) apply(ROWS[i].pins, ROWS[i].exp);
        // low power asked during init is applied when init ends
        @(posedge clock);
        pins_cmd <= 3'h3;
        measure_init(6'h11);
        // no second init on low-power exit
        apply(3'h1, 6'h23);
        // monitor clock: count ticks between two toggles
        @(posedge clock);
        tick_cmd <= 1'b1;
        prev = tx_monitor_clock;
        n = 0;
        toggles = 0;
        for (int i = 0; i < 200 && toggles < 2; i++) begin
            @(negedge clock);
            if (tx_monitor_clock !== prev) begin
                toggles++;
                if (toggles == 2) check(8'(n), 8'd24);
                prev = tx_monitor_clock;
                n = 0;
            end
            if (symbol_tick === 1'b1) n++;
        end
        check(8'(toggles), 8'd2);
        // chip reset in mid-run clears the status; the synchronizer reloads the safe pin levels
        @(posedge clock);
        reset_n <= 1'b0;
        @(negedge clock);
        check(8'(status), 8'h00);
        print_verdict();
    end

    // whole run is well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        print_verdict();
    end
endmodule : testbench
